// ===== hdl/vectored_irq_regs.svh
// register offsets, field positions, reset values and timing counts of the vectored irq unit
`ifndef VECTORED_IRQ_REGS_SVH
`define VECTORED_IRQ_REGS_SVH

`define VECTOR_CTRL_OFS          20'h30000
`define RAW_IRQ_STATUS_OFS       20'h30004
`define IRQ_ENABLE_SET_OFS       20'h30008
`define IRQ_ENABLE_CLEAR_OFS     20'h3000C
`define IRQ_ENABLED_VIEW_OFS     20'h30010
`define PENDING_VECTOR_ADDR_OFS  20'h30014
`define SOFT_IRQ_TRIGGER_OFS     20'h30018
`define IRQ_ACKNOWLEDGE_OFS      20'h3001C
`define VECTOR_TABLE_FIRST_OFS   20'h30020
`define VECTOR_TABLE_LAST_OFS    20'h3003F

`define CTRL_ENABLE_BIT          0
`define CTRL_POLARITY_BIT        1
`define CTRL_EDGE_EMU_BIT        2
`define CTRL_PULSE_LEN_LSB       3
`define CTRL_PULSE_LEN_W         16

`define VECTOR_CTRL_RESET        32'h0000_0000
`define VECTOR_ENTRY_FIRST       32'h0005_2000
`define VECTOR_ENTRY_SECOND      32'h0007_2000

// emulated pulse length unit is one clock cycle
`define PULSE_LEN_MIN_CYCLES     16'h0001

`endif

// ===== hdl/vectored_irq_pkg.sv
// types of the vectored irq unit
package vectored_irq_pkg;

	typedef struct packed {
		logic        enable;
		logic        polarity;
		logic        edgeEmulation;
		logic [15:0] pulseLength;
	} ctrl_t;

	typedef struct packed {
		logic        strobe;
		logic        write;
		logic [19:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef enum logic [2:0] {
		OUT_IDLE   = 3'b001,
		OUT_ASSERT = 3'b010,
		OUT_GAP    = 3'b100
	} out_state_t;

endpackage

// ===== hdl/vectored_irq_unit.sv
// vectored interrupt combiner merging two embedded_irq_mux lines onto one host line
`timescale 1ns/1ps
`include "vectored_irq_regs.svh"

// Function
// R1: merge all mux request lines into one output
// R2: control bit 0 enables whole controller
// R3: control bit 1 selects output polarity
// R4: edge emulation forces low pulse per acknowledge; code drives the inactive level instead, which is high when control bit 1 is 0
// R5: control field sets pulse length delay
// R6: raw status shows unmasked input levels
// R7: enable-set register ones enable inputs
// R8: enable-clear register ones disable inputs
// R9: enabled view reads current enable bits
// R10: vector register returns pending source address
// R11: soft trigger ones emulate input requests
// R12: acknowledge register ones acknowledge pending inputs
// R13: table words hold both mux addresses
// R14: each mux drives one merged line
// R15: host bridge raises message on rising edge
// R16: software enables, high polarity, both inputs
// R17: assert while enabled pending unacknowledged; lowest vector
module vectored_irq_unit
	import vectored_irq_pkg::*;
#(
	parameter int          NUM_INPUTS  = 2,
	parameter logic [31:0] ENTRY_FIRST = `VECTOR_ENTRY_FIRST,
	parameter logic [31:0] ENTRY_SECOND = `VECTOR_ENTRY_SECOND
) (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  nrst,
	// register access
	input  wire bus_req_t              busReq,
	output logic                       busAck,
	output logic [31:0]                busRdata,
	// interrupt lines from the muxes
	input  wire logic [NUM_INPUTS-1:0] muxIrq,
	// host interrupt line
	output logic                       hostIrq
);

	localparam int TABLE_WORDS = 8;

	ctrl_t                 ctrl;
	logic [NUM_INPUTS-1:0] irqSync1;
	logic [NUM_INPUTS-1:0] irqSync2;
	logic [NUM_INPUTS-1:0] enabled;
	logic [NUM_INPUTS-1:0] softReq;
	logic [NUM_INPUTS-1:0] inService;
	logic [NUM_INPUTS-1:0] pending;
	logic                  anyPending;
	logic [31:0]           vectorTable [TABLE_WORDS];
	out_state_t            outState;
	logic [15:0]           gapCount;
	logic                  rawAssert;
	logic                  activeLevel;
	logic [31:0]           vectorAddr;
	logic                  wrCtrl;
	logic                  wrSet;
	logic                  wrClear;
	logic                  wrSoft;
	logic                  wrAck;

	function automatic logic hit(input logic [19:0] addr, input logic [19:0] ofs);
		hit = busReq.strobe && busReq.write && (addr == ofs);
	endfunction

	assign wrCtrl  = hit(busReq.addr, `VECTOR_CTRL_OFS);
	assign wrSet   = hit(busReq.addr, `IRQ_ENABLE_SET_OFS);
	assign wrClear = hit(busReq.addr, `IRQ_ENABLE_CLEAR_OFS);
	assign wrSoft  = hit(busReq.addr, `SOFT_IRQ_TRIGGER_OFS);
	assign wrAck   = hit(busReq.addr, `IRQ_ACKNOWLEDGE_OFS);

	// vector table, unused words read zero
	generate
		for (genvar w = 0; w < TABLE_WORDS; w++) begin : g_table
			if (w == 0) begin : g_first
				assign vectorTable[w] = ENTRY_FIRST; // [R13]
			end else if (w == 1) begin : g_second
				assign vectorTable[w] = ENTRY_SECOND; // [R13]
			end else begin : g_unused
				assign vectorTable[w] = 32'h0000_0000;
			end
		end
	endgenerate

	// pins are asynchronous to mclk
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irqSync1 <= '0;
			irqSync2 <= '0;
		end else begin
			irqSync1 <= muxIrq;
			irqSync2 <= irqSync1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= ctrl_t'(19'(`VECTOR_CTRL_RESET));
		end else if (wrCtrl) begin
			ctrl.enable        <= busReq.wdata[`CTRL_ENABLE_BIT]; // [R2]
			ctrl.polarity      <= busReq.wdata[`CTRL_POLARITY_BIT]; // [R3]
			ctrl.edgeEmulation <= busReq.wdata[`CTRL_EDGE_EMU_BIT]; // [R4]
			ctrl.pulseLength   <= busReq.wdata[`CTRL_PULSE_LEN_LSB +: `CTRL_PULSE_LEN_W]; // [R5]
		end
	end

	// set wins over clear only when both are written, which cannot happen in one cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			enabled <= '0;
		end else if (wrSet) begin
			enabled <= enabled | busReq.wdata[NUM_INPUTS-1:0]; // [R7]
		end else if (wrClear) begin
			enabled <= enabled & ~busReq.wdata[NUM_INPUTS-1:0]; // [R8]
		end
	end

	// soft request persists until acknowledged; a new trigger beats a same-cycle ack
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			softReq <= '0;
		end else if (wrSoft) begin
			softReq <= softReq | busReq.wdata[NUM_INPUTS-1:0]; // [R11]
		end else if (wrAck) begin
			softReq <= softReq & ~busReq.wdata[NUM_INPUTS-1:0]; // [R12]
		end
	end

	assign pending = (irqSync2 | softReq) & enabled;

	// source being serviced is latched when the line goes active, freed by acknowledge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			inService <= '0;
		end else if (wrAck) begin
			inService <= inService & ~busReq.wdata[NUM_INPUTS-1:0]; // [R12]
		end else if (outState == OUT_IDLE && anyPending && ctrl.enable) begin
			inService <= pending & ~(pending - 1'b1); // [R17]
		end
	end

	assign anyPending = |pending; // [R1]

	always_comb begin
		vectorAddr = 32'h0000_0000;
		for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
			if (pending[i]) begin
				vectorAddr = vectorTable[i]; // [R10] [R17]
			end
		end
	end

	// output sequencer; in emulation a gap after each ack taken in OUT_ASSERT makes a fresh edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			outState <= OUT_IDLE;
			gapCount <= 16'h0000;
		end else begin
			unique case (outState)
				OUT_IDLE: begin
					if (ctrl.enable && anyPending) begin
						outState <= OUT_ASSERT; // [R17]
					end
				end
				OUT_ASSERT: begin
					if (!ctrl.enable) begin
						outState <= OUT_IDLE; // [R2]
					end else if (wrAck && ctrl.edgeEmulation) begin
						outState <= OUT_GAP; // [R4]
						gapCount <= (ctrl.pulseLength < `PULSE_LEN_MIN_CYCLES) ?
							`PULSE_LEN_MIN_CYCLES : ctrl.pulseLength; // [R5]
					end else if (wrAck || !anyPending) begin
						outState <= OUT_IDLE;
					end
				end
				OUT_GAP: begin
					if (gapCount == 16'h0001) begin
						outState <= OUT_IDLE; // [R5]
					end
					gapCount <= gapCount - 16'h0001;
				end
			endcase
		end
	end

	assign rawAssert = (outState == OUT_ASSERT) && ctrl.enable; // [R2]
	assign activeLevel = ctrl.polarity;

	// registered so the host line is glitch free
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hostIrq <= 1'b0;
		end else begin
			hostIrq <= rawAssert ? activeLevel : ~activeLevel; // [R3] [R4]
		end
	end

	// register reads, one cycle latency, unmapped reads zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busAck   <= 1'b0;
			busRdata <= 32'h0000_0000;
		end else begin
			busAck   <= busReq.strobe;
			busRdata <= 32'h0000_0000;
			if (busReq.strobe && !busReq.write) begin
				if (busReq.addr >= `VECTOR_TABLE_FIRST_OFS &&
					busReq.addr <= `VECTOR_TABLE_LAST_OFS) begin
					busRdata <= vectorTable[busReq.addr[4:2]]; // [R13]
				end else begin
					unique case (busReq.addr)
						`VECTOR_CTRL_OFS: begin
							busRdata[`CTRL_ENABLE_BIT]   <= ctrl.enable;
							busRdata[`CTRL_POLARITY_BIT] <= ctrl.polarity;
							busRdata[`CTRL_EDGE_EMU_BIT] <= ctrl.edgeEmulation;
							busRdata[`CTRL_PULSE_LEN_LSB +: `CTRL_PULSE_LEN_W] <=
								ctrl.pulseLength;
						end
						`RAW_IRQ_STATUS_OFS: begin
							busRdata[NUM_INPUTS-1:0] <= irqSync2; // [R6]
						end
						`IRQ_ENABLED_VIEW_OFS: begin
							busRdata[NUM_INPUTS-1:0] <= enabled; // [R9]
						end
						`PENDING_VECTOR_ADDR_OFS: begin
							busRdata <= vectorAddr; // [R10]
						end
						default: begin
							busRdata <= 32'h0000_0000;
						end
					endcase
				end
			end
		end
	end

endmodule

// ===== testbench/irq_partner_model.sv
// partner model: two irq muxes feeding the unit and the host bridge behind it
`timescale 1ns/1ps
module irq_partner_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// mux sources, four per mux, and extra latency select
	input  wire logic [7:0] src,
	input  wire logic       slow,
	output logic      [1:0] muxIrq,
	// host side
	input  wire logic       hostIrq,
	output logic      [7:0] msiCount
);
	logic [1:0] merged;
	logic       hostLast;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			merged <= 2'h0;
			muxIrq <= 2'h0;
		end else begin
			merged <= {|src[7:4], |src[3:0]};
			muxIrq <= slow ? merged : {|src[7:4], |src[3:0]};
		end
	end
	// bridge counts one message per rising edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hostLast <= 1'b0;
			msiCount <= 8'h0;
		end else begin
			hostLast <= hostIrq;
			msiCount <= msiCount + 8'((hostIrq && !hostLast));
		end
	end
endmodule

// ===== testbench/vectored_irq_unit_props.sv
// port checks of the vectored irq unit
`timescale 1ns/1ps
module vectored_irq_unit_props
	import vectored_irq_pkg::*;
#(
	parameter int NUM_INPUTS = 2
) (
	// clock and reset
	input wire logic                  mclk,
	input wire logic                  nrst,
	// register access
	input wire bus_req_t              busReq,
	input wire logic                  busAck,
	input wire logic [31:0]           busRdata,
	// irq lines
	input wire logic [NUM_INPUTS-1:0] muxIrq,
	input wire logic                  hostIrq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic [19:0] ra;
	logic        en;
	logic        output_polarity;
	assign ra = (busReq.strobe && !busReq.write) ? busReq.addr : 20'h0;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			en <= 1'b0;
			output_polarity <= 1'b0;
		end else if (busReq.strobe && busReq.write && busReq.addr == 20'h30000) begin
			en <= busReq.wdata[0];
			output_polarity <= busReq.wdata[1];
		end
	end
	raw_width_a: assert property (ra == 20'h30004 |=> busRdata[31:2] == 30'h0)
		else $error("raw status upper bits set");
	raw_live_a: assert property ($stable(muxIrq) [*5] ##0 ra == 20'h30004
		|=> busRdata[1:0] == $past(muxIrq)) else $error("raw status wrong");
	view_width_a: assert property (ra == 20'h30010 |=> busRdata[31:2] == 30'h0)
		else $error("enabled view upper bits set");
	entry_first_a: assert property (ra == 20'h30020 |=> busRdata == 32'h52000)
		else $error("first entry wrong");
	entry_second_a: assert property (ra == 20'h30024 |=> busRdata == 32'h72000)
		else $error("second entry wrong");
	entry_unused_a: assert property (ra inside {[20'h30028:20'h3003C]} |=> busRdata == 32'h0)
		else $error("unused entry not zero");
	vector_value_a: assert property (ra == 20'h30014
		|=> busRdata inside {32'h0, 32'h52000, 32'h72000}) else $error("bad vector");
	disabled_idle_a: assert property ((!en && $stable(output_polarity)) [*4] |-> hostIrq == !output_polarity)
		else $error("host line active while disabled");
	cover property (ra == 20'h30014 ##1 busRdata == 32'h72000);
	cover property ($rose(hostIrq) && output_polarity);
	cover property (busReq.strobe && busReq.write && busReq.addr == 20'h3001C);
endmodule

bind vectored_irq_unit vectored_irq_unit_props #(.NUM_INPUTS(NUM_INPUTS)) props (
	.mclk(mclk), .nrst(nrst), .busReq(busReq), .busAck(busAck), .busRdata(busRdata),
	.muxIrq(muxIrq), .hostIrq(hostIrq));

// ===== testbench/testbench.sv
// self-checking bench of the vectored irq unit
`timescale 1ns/1ps
module testbench;
	import vectored_irq_pkg::*;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	bus_req_t    busReq = '0;
	logic        busAck;
	logic [31:0] busRdata;
	logic [1:0]  muxIrq;
	logic        hostIrq;
	logic [7:0]  src = 8'h0;
	logic        slow = 1'b0;
	logic [7:0]  msiCount;
	logic [7:0]  msiBefore;
	logic [32:0] notes[$];
	logic [32:0] note;
	int          errors;
	int          check_count;
	int          cycles;
	int          seed = 32'hDD1D;
	vectored_irq_unit DUT (.mclk(mclk), .nrst(nrst), .busReq(busReq), .busAck(busAck),
		.busRdata(busRdata), .muxIrq(muxIrq), .hostIrq(hostIrq));
	irq_partner_model far (.mclk(mclk), .nrst(nrst), .src(src), .slow(slow),
		.muxIrq(muxIrq), .hostIrq(hostIrq), .msiCount(msiCount));
	always #25 mclk = ~mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// reads note the expected data, writes are noted unchecked
	task automatic acc(input logic w, input logic [7:0] o, input logic [31:0] d);
		@(negedge mclk);
		busReq <= '{1'b1, w, {12'h300, o}, d};
		notes.push_back({!w, d});
		@(negedge mclk);
		busReq.strobe <= 1'b0;
	endtask
	task automatic hi(input int n, input logic e);
		repeat (n) @(negedge mclk);
		check(32'(hostIrq), 32'(e));
	endtask
	always @(negedge mclk) begin
		if (busAck === 1'b1) begin
			note = notes.pop_front();
			if (note[32]) check(busRdata, note[31:0]);
		end
	end
	// whole sequence needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		repeat (10) @(negedge mclk);
		nrst = 1'b1;
		acc(0, 8'h00, 32'h0);
		acc(0, 8'h20, 32'h52000);
		acc(0, 8'h24, 32'h72000);
		acc(0, 8'h3C, 32'h0);
		acc(1, 8'h00, 32'h3);
		acc(1, 8'h08, 32'h3);
		acc(1, 8'h08, 32'h0);
		acc(1, 8'h0C, 32'h1);
		acc(1, 8'h0C, 32'h0);
		acc(0, 8'h10, 32'h2);
		acc(1, 8'h08, 32'h1);
		acc(0, 8'h10, 32'h3);
		slow = 1'($random(seed));
		src = {4'h0, 4'h1 | 4'($random(seed))};
		hi(8, 1'b1);
		acc(0, 8'h04, 32'h1);
		acc(0, 8'h14, 32'h52000);
		src[7:4] = 4'h8;
		hi(8, 1'b1);
		acc(0, 8'h04, 32'h3);
		acc(0, 8'h14, 32'h52000);
		src[3:0] = 4'h0;
		acc(1, 8'h1C, 32'h1);
		hi(8, 1'b1);
		acc(0, 8'h14, 32'h72000);
		src = 8'h0;
		acc(1, 8'h1C, 32'h2);
		hi(8, 1'b0);
		acc(0, 8'h14, 32'h0);
		acc(1, 8'h18, 32'h2);
		hi(6, 1'b1);
		acc(0, 8'h14, 32'h72000);
		acc(1, 8'h1C, 32'h2);
		acc(1, 8'h00, 32'h1);
		hi(6, 1'b1);
		src = 8'h1;
		acc(1, 8'h00, 32'h2);
		hi(6, 1'b0);
		// pulse length five cycles, edge emulation, high polarity
		acc(1, 8'h00, 32'h2F);
		hi(6, 1'b1);
		msiBefore = msiCount;
		acc(1, 8'h1C, 32'h1);
		hi(2, 1'b0);
		hi(2, 1'b0);
		hi(14, 1'b1);
		check(32'(msiCount), 32'(msiBefore + 8'h1));
		check(32'(notes.size()), 32'h0);
		close_out();
	end
endmodule
